// ### bench/dac_playback_mute_mix_control_asserts.sv
// Purpose: port checks of the playback control block
// Assumes: one clock, srst synchronous active high
// Notes:   bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module dac_playback_mute_mix_control_asserts (
	// clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          srst,
	// bus
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	input  wire logic                          hreadyout,
	input  wire logic                          hresp,
	// stream and controls
	input  wire logic                          sample_valid,
	input  wire logic                          out_valid,
	input  wire dac_pkg::stereo_s              out_sample,
	input  wire logic                          sloped_rejection_select,
	input  wire logic                          double_oversample_select,
	input  wire logic                          left_phones_gain_on,
	input  wire dac_pkg::route_e [3:0]         output_route,
	input  wire logic [3:0][7:0]               output_level
);
	// ---------------------------------------------------------------
	// write tracking
	// ---------------------------------------------------------------
	localparam logic [31:0] A_CFG = {20'h0, dac_pkg::IDX_CFG, 2'h0};
	localparam logic [31:0] A_PH  = {20'h0, dac_pkg::IDX_PHONES, 2'h0};
	localparam logic [31:0] A_RT  = {20'h0, dac_pkg::IDX_ROUTE, 2'h0};
	localparam logic [31:0] A_LV  = {20'h0, dac_pkg::IDX_OUTLVL, 2'h0};
	logic        take;
	logic        wr_q;
	logic [31:0] a_q;

	assign take = hsel && hready && htrans[1];

	// marks the data phase of a word write; address only matters then
	always_ff @(posedge core_clk) begin
		if (take) begin
			a_q <= haddr;
		end
		if (srst) begin
			wr_q <= 1'b0;
		end else begin
			wr_q <= take && hwrite && (hsize == 3'h2);
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	a_resp_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
	a_out_lag: assert property (sample_valid |-> ##2 out_valid) else $error("output sample late");
	a_out_cause: assert property (out_valid |-> $past(sample_valid, 2)) else $error("output without input");
	a_out_hold: assert property (!out_valid |-> $stable(out_sample)) else $error("output changed idle");
	a_osr_write: assert property (
		wr_q && a_q == A_CFG |=> double_oversample_select == $past(hwdata[6])) else $error("osr select wrong");
	a_sloped_write: assert property (
		wr_q && a_q == A_CFG |=> sloped_rejection_select == $past(hwdata[11])) else $error("sloped select wrong");
	a_route_write: assert property (
		wr_q && a_q == A_RT |=> output_route == $past(hwdata[7:0])) else $error("route wrong");
	a_level_write: assert property (
		wr_q && a_q == A_LV |=> output_level == $past(hwdata)) else $error("output level wrong");
	a_phones_off: assert property (
		wr_q && a_q == A_PH && !hwdata[1] |-> ##2 !left_phones_gain_on) else $error("phones stage stays on");

	c_stream: cover property (sample_valid ##2 out_valid);
	c_read: cover property (take && !hwrite ##2 hreadyout);
	c_cfg: cover property (wr_q && a_q == A_CFG);
endmodule
`default_nettype wire

// ### bench/playback_source.sv
// Purpose: upstream sample source feeding the playback block
// Assumes: one sample every third clock while go is high
// Notes:   between samples the data shows the inverse value
`timescale 1ns/1ps
`default_nettype none
module playback_source (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             srst,
	// control
	input  wire logic             go,
	input  wire dac_pkg::stereo_s value,
	// stream
	output logic                  sample_valid,
	output dac_pkg::stereo_s      sample_in
);
	// ---------------------------------------------------------------
	// pacing
	// ---------------------------------------------------------------
	logic [1:0] cnt_q;

	// counter restarts on stop, so each burst starts clean
	always_ff @(posedge core_clk) begin
		if (srst || !go) begin
			cnt_q <= 2'h0;
			sample_valid <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
			sample_valid <= (cnt_q == 2'h2);
		end
	end

	// no stale data between pulses
	assign sample_in = sample_valid ? value : dac_pkg::stereo_s'(~value);
endmodule
`default_nettype wire

// ### bench/tb_dac_playback_mute_mix_control.sv
// Purpose: self-checking bench of the playback control block
// Assumes: reads take one wait state, writes none
// Notes:   register rows first, then reset and stream cases
`timescale 1ns/1ps
`default_nettype none
module tb_dac_playback_mute_mix_control;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} row_s;
	localparam dac_pkg::stereo_s STIM = {24'h000100, 24'h000300};
	logic                     core_clk = 1'b0;
	logic                     srst = 1'b1;
	logic                     hsel = 1'b0;
	logic                     hwrite = 1'b0;
	logic                     go = 1'b0;
	logic [31:0]              haddr = 32'h0;
	logic [31:0]              hwdata = 32'h0;
	logic [31:0]              rdq;
	logic [1:0]               htrans = 2'h0;
	logic [2:0]               hsize = 3'h2;
	wire logic                hready, hreadyout, hresp, sample_valid, out_valid;
	wire logic [31:0]         hrdata;
	wire dac_pkg::stereo_s    sample_in, out_sample;
	wire logic                sloped_rejection_select, double_oversample_select;
	wire logic                left_phones_gain_on, right_phones_gain_on, left_line_gain_on, right_line_gain_on;
	wire dac_pkg::route_e [3:0] output_route;
	wire logic [3:0][7:0]     output_level;
	int                       n_errors = 0;
	int                       n_compared = 0;
	int                       cyc = 0;
	row_s rows [9] = '{'{32'h38, 32'hffffffff, 32'h3}, '{32'h3c, 32'h2, 32'h2},
		'{32'h84, 32'hffffffff, 32'h1e4e}, '{32'h84, 32'h1002, 32'h1002}, '{32'h84, 32'ha04, 32'ha04},
		'{32'h84, 32'h446, 32'h446}, '{32'h90, 32'h1b, 32'h1b}, '{32'h94, 32'h11223344, 32'h11223344},
		'{32'h400, 32'h5, 32'h0}};

	// the single slave's ready is the bus ready
	assign hready = hreadyout;

	always #4 core_clk = ~core_clk;

	dac_playback_mute_mix_control i_dut (.core_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .sample_valid, .sample_in, .out_valid, .out_sample,
		.sloped_rejection_select, .double_oversample_select, .left_phones_gain_on, .right_phones_gain_on,
		.left_line_gain_on, .right_line_gain_on, .output_route, .output_level);

	playback_source i_src (.core_clk, .srst, .go, .value(STIM), .sample_valid, .sample_in);

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one word transfer, address phase then data phase
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge core_clk);
		while (!hready) @(posedge core_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge core_clk);
		while (!hready) @(posedge core_clk);
		rdq = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		repeat (2) @(posedge core_clk);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("hrdata", rdq, e);
	endtask

	// even counts keep the divider phase
	task automatic send(input int n);
		int k = 0;
		go <= 1'b1;
		while (k < n) begin
			@(posedge core_clk);
			if (sample_valid) k++;
		end
		go <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic results;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			results();
		end
	end

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			bus(1'b1, rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		chk("osr", double_oversample_select, 1'b1);
		chk("sloped", sloped_rejection_select, 1'b0);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd(32'h84, 32'h8);
		rd(32'h38, 32'h0);
		rd(32'h3c, 32'h0);
		wr(32'h88, 32'h3);
		send(2);
		chk("muted", out_sample, 48'h0);
		wr(32'h84, 32'h0);
		rd(32'h98, 32'hc0c0);
		send(2);
		chk("stereo", out_sample, STIM);
		wr(32'h88, 32'h2);
		wr(32'h84, 32'h1000);
		send(2);
		chk("mono", out_sample, {24'h000200, 24'h0});
		wr(32'h88, 32'h3);
		send(2);
		chk("both on", out_sample, STIM);
		wr(32'h84, 32'h6);
		wr(32'h8c, 32'h0);
		send(2);
		chk("emph", out_sample, {24'h000010, 24'h000030});
		wr(32'h84, 32'h0);
		wr(32'h8c, 32'h0404);
		wr(32'h84, 32'h8);
		send(4);
		rd(32'h98, 32'h00030202);
		send(4);
		rd(32'h98, 32'h0);
		wr(32'h84, 32'h600);
		send(32);
		rd(32'h98, 32'h00030101);
		wr(32'h38, 32'h3);
		chk("phones", {left_phones_gain_on, right_phones_gain_on}, 2'h0);
		wr(32'h88, 32'hf);
		chk("phones", {left_phones_gain_on, right_phones_gain_on}, 2'h3);
		wr(32'h3c, 32'h1);
		chk("line", {left_line_gain_on, right_line_gain_on}, 2'h1);
		wr(32'h38, 32'h0);
		chk("phones", {left_phones_gain_on, right_phones_gain_on}, 2'h0);
		results();
	end
endmodule

bind dac_playback_mute_mix_control dac_playback_mute_mix_control_asserts i_chk (.core_clk, .srst, .hsel,
	.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .sample_valid, .out_valid,
	.out_sample, .sloped_rejection_select, .double_oversample_select, .left_phones_gain_on, .output_route,
	.output_level);
`default_nettype wire

// ### rtl/dac_pkg.sv
// Purpose: shared constants, types and register map of the playback control block
// Assumes: 32-bit AHB-Lite register access, one aligned word per register index
// Notes:   byte address of a register is ADDR_STRIDE times its index
package dac_pkg;

	// ---------------------------------------------------------------
	// register indices
	// ---------------------------------------------------------------
	localparam int unsigned ADDR_STRIDE = 4;
	localparam logic [9:0]  IDX_PHONES  = 10'h00e;
	localparam logic [9:0]  IDX_LINE    = 10'h00f;
	localparam logic [9:0]  IDX_CFG     = 10'h021;
	localparam logic [9:0]  IDX_CONV    = 10'h022;
	localparam logic [9:0]  IDX_LEVELS  = 10'h023;
	localparam logic [9:0]  IDX_ROUTE   = 10'h024;
	localparam logic [9:0]  IDX_OUTLVL  = 10'h025;
	localparam logic [9:0]  IDX_STATUS  = 10'h026;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int unsigned LEFT_GAIN_ON_BIT  = 1;
	localparam int unsigned RIGHT_GAIN_ON_BIT = 0;
	localparam int unsigned CFG_MONO_BIT      = 12;
	localparam int unsigned CFG_SLOPED_BIT    = 11;
	localparam int unsigned CFG_FADE_BIT      = 10;
	localparam int unsigned CFG_GRADUAL_BIT   = 9;
	localparam int unsigned CFG_OSR_BIT       = 6;
	localparam int unsigned CFG_MUTE_BIT      = 3;
	localparam int unsigned CFG_EMPH_LSB      = 1;
	localparam int unsigned CONV_RIGHT_BIT    = 0;
	localparam int unsigned CONV_LEFT_BIT     = 1;
	localparam int unsigned CONV_MIDRAIL_BIT  = 2;
	localparam int unsigned CONV_BIAS_BIT     = 3;
	localparam int unsigned STAT_BUSY_LSB     = 16;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [1:0]  PHONES_RESET = 2'h0;
	localparam logic [1:0]  LINE_RESET   = 2'h0;
	localparam logic [3:0]  CONV_RESET   = 4'h0;
	localparam logic [15:0] LEVELS_RESET = 16'hc0c0;
	localparam logic [7:0]  ROUTE_RESET  = 8'h00;
	localparam logic [31:0] OUTLVL_RESET = 32'h00000000;

	// ---------------------------------------------------------------
	// gain, ramp and filter constants
	// ---------------------------------------------------------------
	localparam int unsigned SAMPLE_W          = 24;
	localparam logic [7:0]  UNITY_CODE        = 8'hc0;
	localparam logic [5:0]  FAST_RAMP_SAMPLES = 6'h02;
	localparam logic [5:0]  SLOW_RAMP_SAMPLES = 6'h20;
	// one-pole smoothing factors in q15, plain defaults
	localparam logic [14:0] EMPH_K_32K        = 15'h5000;
	localparam logic [14:0] EMPH_K_44K1       = 15'h5800;
	localparam logic [14:0] EMPH_K_48K        = 15'h6000;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {EMPH_OFF, EMPH_32K, EMPH_44K1, EMPH_48K} emph_e;
	typedef enum logic [1:0] {ROUTE_DAC, ROUTE_LEFT_THROUGH, ROUTE_RIGHT_THROUGH, ROUTE_NONE} route_e;

	typedef struct packed {
		logic  mono;
		logic  sloped;
		logic  fade_slow;
		logic  gradual;
		logic  double_os;
		logic  mute;
		emph_e emph;
	} play_cfg_s;

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] left;
		logic signed [SAMPLE_W-1:0] right;
	} stereo_s;

	localparam play_cfg_s CFG_RESET = '{mono: 1'b0, sloped: 1'b0, fade_slow: 1'b0, gradual: 1'b0,
		double_os: 1'b0, mute: 1'b1, emph: EMPH_OFF};

endpackage

// ### rtl/dac_playback_mute_mix_control.sv
// Purpose: playback mute ramp, mono mix, de-emphasis and output enable control
// Assumes: one AHB-Lite master, word transfers; sample_valid one pulse per fs
// Notes:   reads take one wait state, writes none
//
// Contract
// - mute lowers the output gain step by step to silence
// - mute bit 3 resets to one; zero un-mutes, one mutes
// - bit 9 picks instant restore or gradual climb on un-mute
// - bit 10 picks ramp fs/2 or fs/32, reset zero
// - ramp time grows with level gap, at most 10.7ms or 171ms
// - mono bit 12 sums both channels with a 6dB cut
// - mono mix drives only the enabled channel, silence on the other
// - both channels on means stereo even with mono selected
// - bits 2:1 pick no de-emphasis, 32k, 44.1k or 48k
// - de-emphasis only for 48k, 44.1k and 32k rates
// - bit 11 picks normal or sloped stopband; sloped advised at 24k or less
// - bit 6 doubles oversampling; reset zero is low power
// - outputs default to same-side converter, selectable analog through path
// - each analog output has own enable and own level
// - phones gain stages on bits 1 and 0, reset off
// - line gain stages on bits 1 and 0, reset off
`timescale 1ns/1ps
`default_nettype none
module dac_playback_mute_mix_control (
	// clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          srst,
	// ahb-lite slave
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic                               hreadyout,
	output logic                               hresp,
	output logic [31:0]                        hrdata,
	// playback stream in
	input  wire logic                          sample_valid,
	input  wire dac_pkg::stereo_s              sample_in,
	// processed stream out
	output logic                               out_valid,
	output dac_pkg::stereo_s                   out_sample,
	// converter modulator controls
	output logic                               sloped_rejection_select,
	output logic                               double_oversample_select,
	// analog gain stage enables
	output logic                               left_phones_gain_on,
	output logic                               right_phones_gain_on,
	output logic                               left_line_gain_on,
	output logic                               right_line_gain_on,
	// analog routing and levels
	output dac_pkg::route_e [3:0]              output_route,
	output logic            [3:0][7:0]         output_level
);

	localparam int unsigned SW = dac_pkg::SAMPLE_W;

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	dac_pkg::play_cfg_s cfg_q;
	logic [1:0]         phones_q;
	logic [1:0]         line_q;
	logic [3:0]         conv_q;
	logic [15:0]        levels_q;
	logic [7:0]         route_q;
	logic [31:0]        outlvl_q;

	logic               hreadyout_q;
	logic [31:0]        hrdata_q;
	logic               rd_pend_q;
	logic               wr_pend_q;
	logic               ok_q;
	logic [9:0]         word_q;
	logic               take;

	logic [1:0][7:0]    applied;
	logic [1:0]         busy;
	logic [1:0][7:0]    target;
	logic [5:0]         step_count_q;
	logic               step_tick_q;
	logic [5:0]         period;

	logic               left_on;
	logic               right_on;
	logic               mono_active;
	logic [SW:0]        mix_sum;
	logic [1:0][SW-1:0] pre;
	logic [1:0][SW-1:0] scaled_q;
	logic               scaled_valid_q;
	logic [1:0]         filt_valid;
	logic [1:0][SW-1:0] filt_sample;
	logic [3:0]         stage_on_q;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// code to linear factor, 256 is unity; a coarse fit of the dB table
	function automatic logic [8:0] gain_factor(input logic [7:0] code);
		if (code >= dac_pkg::UNITY_CODE) begin
			return 9'h100;
		end
		return {1'b0, code} + {3'b000, code[7:2]} + {5'b00000, code[7:4]} + {7'b0000000, code[7:6]};
	endfunction

	function automatic logic [SW-1:0] apply_gain(input logic [SW-1:0] s, input logic [7:0] code);
		logic signed [SW+9:0] p;
		logic signed [SW+9:0] sh;
		p  = $signed(s) * $signed({1'b0, gain_factor(code)});
		sh = p >>> 8;
		return sh[SW-1:0];
	endfunction

	function automatic logic [31:0] read_word(input logic [9:0] w);
		logic [31:0] r;
		r = 32'h00000000;
		unique case (w)
			dac_pkg::IDX_PHONES: r[1:0] = phones_q;
			dac_pkg::IDX_LINE:   r[1:0] = line_q;
			dac_pkg::IDX_CFG: begin
				r[dac_pkg::CFG_MONO_BIT]                   = cfg_q.mono;
				r[dac_pkg::CFG_SLOPED_BIT]                 = cfg_q.sloped;
				r[dac_pkg::CFG_FADE_BIT]                   = cfg_q.fade_slow;
				r[dac_pkg::CFG_GRADUAL_BIT]                = cfg_q.gradual;
				r[dac_pkg::CFG_OSR_BIT]                    = cfg_q.double_os;
				r[dac_pkg::CFG_MUTE_BIT]                   = cfg_q.mute;
				r[dac_pkg::CFG_EMPH_LSB +: 2]              = cfg_q.emph;
			end
			dac_pkg::IDX_CONV:   r[3:0]  = conv_q;
			dac_pkg::IDX_LEVELS: r[15:0] = levels_q;
			dac_pkg::IDX_ROUTE:  r[7:0]  = route_q;
			dac_pkg::IDX_OUTLVL: r       = outlvl_q;
			dac_pkg::IDX_STATUS: r       = {14'h0000, busy[0], busy[1], applied[0], applied[1]};
			default:             r       = 32'h00000000;
		endcase
		return r;
	endfunction

	// ---------------------------------------------------------------
	// ahb-lite slave
	// ---------------------------------------------------------------
	assign take = hsel && hready && htrans[1];

	// reads stall one cycle so a write just before is already visible
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hreadyout_q <= 1'b1;
			hrdata_q    <= 32'h00000000;
			rd_pend_q   <= 1'b0;
			wr_pend_q   <= 1'b0;
			ok_q        <= 1'b0;
			word_q      <= 10'h000;
		end else begin
			wr_pend_q <= take && hwrite;
			if (rd_pend_q) begin
				hrdata_q    <= ok_q ? read_word(word_q) : 32'h00000000;
				hreadyout_q <= 1'b1;
				rd_pend_q   <= 1'b0;
			end else if (take) begin
				word_q <= haddr[11:2];
				ok_q   <= (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
				if (!hwrite) begin
					rd_pend_q   <= 1'b1;
					hreadyout_q <= 1'b0;
				end
			end
		end
	end

	assign hreadyout = hreadyout_q;
	assign hrdata    = hrdata_q;
	assign hresp     = 1'b0; // constant okay, tied low from reset

	// software writes; unmapped words are dropped
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cfg_q    <= dac_pkg::CFG_RESET;
			phones_q <= dac_pkg::PHONES_RESET;
			line_q   <= dac_pkg::LINE_RESET;
			conv_q   <= dac_pkg::CONV_RESET;
			levels_q <= dac_pkg::LEVELS_RESET;
			route_q  <= dac_pkg::ROUTE_RESET;
			outlvl_q <= dac_pkg::OUTLVL_RESET;
		end else if (wr_pend_q && ok_q) begin
			unique case (word_q)
				dac_pkg::IDX_PHONES: phones_q <= hwdata[1:0];
				dac_pkg::IDX_LINE:   line_q   <= hwdata[1:0];
				dac_pkg::IDX_CFG: begin
					cfg_q.mono      <= hwdata[dac_pkg::CFG_MONO_BIT];
					cfg_q.sloped    <= hwdata[dac_pkg::CFG_SLOPED_BIT];
					cfg_q.fade_slow <= hwdata[dac_pkg::CFG_FADE_BIT];
					cfg_q.gradual   <= hwdata[dac_pkg::CFG_GRADUAL_BIT];
					cfg_q.double_os <= hwdata[dac_pkg::CFG_OSR_BIT];
					cfg_q.mute      <= hwdata[dac_pkg::CFG_MUTE_BIT];
					cfg_q.emph      <= dac_pkg::emph_e'(hwdata[dac_pkg::CFG_EMPH_LSB +: 2]);
				end
				dac_pkg::IDX_CONV:   conv_q   <= hwdata[3:0];
				dac_pkg::IDX_LEVELS: levels_q <= hwdata[15:0];
				dac_pkg::IDX_ROUTE:  route_q  <= hwdata[7:0];
				dac_pkg::IDX_OUTLVL: outlvl_q <= hwdata;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// ramp timing and gain
	// ---------------------------------------------------------------
	assign period = cfg_q.fade_slow ? dac_pkg::SLOW_RAMP_SAMPLES : dac_pkg::FAST_RAMP_SAMPLES;

	// tick once every period samples; full-scale ramp time follows
	always_ff @(posedge core_clk) begin
		if (srst) begin
			step_count_q <= 6'h00;
			step_tick_q  <= 1'b0;
		end else begin
			step_tick_q <= 1'b0;
			if (sample_valid) begin
				if (step_count_q >= period - 6'h01) begin
					step_count_q <= 6'h00;
					step_tick_q  <= 1'b1;
				end else begin
					step_count_q <= step_count_q + 6'h01;
				end
			end
		end
	end

	assign target[1] = levels_q[15:8];
	assign target[0] = levels_q[7:0];

	// index 1 is left, 0 is right
	generate
		for (genvar c = 0; c < 2; c++) begin : g_chan
			gain_ramp u_ramp (
				.core_clk  (core_clk),
				.srst      (srst),
				.step_tick (step_tick_q),
				.mute      (cfg_q.mute),
				.gradual   (cfg_q.gradual),
				.target    (target[c]),
				.applied_q (applied[c]),
				.busy_q    (busy[c])
			);
			emphasis_filter #(.W(SW)) u_emph (
				.core_clk     (core_clk),
				.srst         (srst),
				.in_valid     (scaled_valid_q),
				.in_sample    (scaled_q[c]),
				.select       (cfg_q.emph),
				.out_valid_q  (filt_valid[c]),
				.out_sample_q (filt_sample[c])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// mono mix and gain
	// ---------------------------------------------------------------
	assign left_on     = conv_q[dac_pkg::CONV_LEFT_BIT];
	assign right_on    = conv_q[dac_pkg::CONV_RIGHT_BIT];
	assign mono_active = cfg_q.mono && (left_on != right_on);
	assign mix_sum     = {sample_in.left[SW-1], sample_in.left} + {sample_in.right[SW-1], sample_in.right};

	// halving the sum gives the 6dB headroom; an off channel stays silent
	always_comb begin
		pre[1] = mono_active ? mix_sum[SW:1] : sample_in.left;
		pre[0] = mono_active ? mix_sum[SW:1] : sample_in.right;
		if (!left_on) begin
			pre[1] = '0;
		end
		if (!right_on) begin
			pre[0] = '0;
		end
	end

	// gain applied before de-emphasis
	always_ff @(posedge core_clk) begin
		if (srst) begin
			scaled_valid_q <= 1'b0;
			scaled_q       <= '0;
		end else begin
			scaled_valid_q <= sample_valid;
			if (sample_valid) begin
				scaled_q[1] <= apply_gain(pre[1], applied[1]);
				scaled_q[0] <= apply_gain(pre[0], applied[0]);
			end
		end
	end

	assign out_valid        = filt_valid[1];
	assign out_sample.left  = filt_sample[1];
	assign out_sample.right = filt_sample[0];

	// ---------------------------------------------------------------
	// analog side controls
	// ---------------------------------------------------------------
	// stages held off until reference and bias are both up
	always_ff @(posedge core_clk) begin
		if (srst) begin
			stage_on_q <= 4'h0;
		end else begin
			stage_on_q <= {phones_q, line_q} & {4{conv_q[dac_pkg::CONV_MIDRAIL_BIT] && conv_q[dac_pkg::CONV_BIAS_BIT]}};
		end
	end

	assign left_phones_gain_on      = stage_on_q[3];
	assign right_phones_gain_on     = stage_on_q[2];
	assign left_line_gain_on        = stage_on_q[1];
	assign right_line_gain_on       = stage_on_q[0];
	assign sloped_rejection_select  = cfg_q.sloped;
	assign double_oversample_select = cfg_q.double_os;

	// per-output source and level, each independent
	generate
		for (genvar o = 0; o < 4; o++) begin : g_out
			assign output_route[o] = dac_pkg::route_e'(route_q[2*o +: 2]);
			assign output_level[o] = outlvl_q[8*o +: 8];
		end
	endgenerate

endmodule
`default_nettype wire

// ### rtl/emphasis_filter.sv
// Purpose: selectable first-order de-emphasis of one sample channel
// Assumes: in_valid marks one sample per fs period
// Notes:   output is registered, one cycle after the input sample
`timescale 1ns/1ps
`default_nettype none
module emphasis_filter #(
	parameter int unsigned W = 24
) (
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                srst,
	// sample in
	input  wire logic                in_valid,
	input  wire logic signed [W-1:0] in_sample,
	input  wire dac_pkg::emph_e      select,
	// sample out
	output logic                     out_valid_q,
	output logic signed      [W-1:0] out_sample_q
);

	logic        [14:0]   k;
	logic signed [W:0]    diff;
	logic signed [W+16:0] prod;
	logic signed [W+16:0] shifted;
	logic signed [W+1:0]  next;

	// factor per rate; the off code bypasses the pole
	always_comb begin
		unique case (select)
			dac_pkg::EMPH_OFF:  k = 15'h0000;
			dac_pkg::EMPH_32K:  k = dac_pkg::EMPH_K_32K;
			dac_pkg::EMPH_44K1: k = dac_pkg::EMPH_K_44K1;
			dac_pkg::EMPH_48K:  k = dac_pkg::EMPH_K_48K;
		endcase
	end

	// y = y1 + k*(x - y1); k below one so the sum stays in range
	assign diff    = {in_sample[W-1], in_sample} - {out_sample_q[W-1], out_sample_q};
	assign prod    = diff * $signed({1'b0, k});
	assign shifted = prod >>> 15;
	assign next    = {out_sample_q[W-1], out_sample_q[W-1], out_sample_q} + {shifted[W], shifted[W:0]};

	// state doubles as output
	always_ff @(posedge core_clk) begin
		if (srst) begin
			out_valid_q  <= 1'b0;
			out_sample_q <= '0;
		end else begin
			out_valid_q <= in_valid;
			if (in_valid) begin
				if (select == dac_pkg::EMPH_OFF) begin
					out_sample_q <= in_sample;
				end else begin
					out_sample_q <= next[W-1:0];
				end
			end
		end
	end

endmodule
`default_nettype wire

// ### rtl/gain_ramp.sv
// Purpose: applied gain code of one channel, stepped toward mute, or toward the set level only when gradual is set
// Assumes: step_tick is a one-cycle pulse once per ramp period
// Notes:   code 0 is silence
`timescale 1ns/1ps
`default_nettype none
module gain_ramp (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       srst,
	// control
	input  wire logic       step_tick,
	input  wire logic       mute,
	input  wire logic       gradual,
	input  wire logic [7:0] target,
	// state
	output logic      [7:0] applied_q,
	output logic            busy_q
);

	logic [7:0] goal;

	// mute aims at silence, otherwise at the channel level
	assign goal = mute ? 8'h00 : target;

	// one code per tick; instant restore when not gradual
	always_ff @(posedge core_clk) begin
		if (srst) begin
			applied_q <= 8'h00;
		end else if (!mute && !gradual) begin
			applied_q <= target;
		end else if (step_tick) begin
			if (applied_q < goal) begin
				applied_q <= applied_q + 8'h01;
			end else if (applied_q > goal) begin
				applied_q <= applied_q - 8'h01;
			end
		end
	end

	// busy lags the gain by one cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (applied_q != goal);
		end
	end

endmodule
`default_nettype wire
